// *** design/bbrpg_pkg.sv ***
package bbrpg_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_COUNT  = 12'h000;
  localparam logic [11:0] OFF_MATCHA = 12'h004;
  localparam logic [11:0] OFF_MATCHB = 12'h008;
  localparam logic [11:0] OFF_LOAD   = 12'h00C;
  localparam logic [11:0] OFF_CTRL   = 12'h010;
  localparam logic [11:0] OFF_MASK   = 12'h014;
  localparam logic [11:0] OFF_RAW    = 12'h018;
  localparam logic [11:0] OFF_MIS    = 12'h01C;
  localparam logic [11:0] OFF_CLR    = 12'h020;
  localparam logic [11:0] OFF_TRIM   = 12'h024;
  localparam logic [11:0] OFF_DATA0  = 12'h030;
  localparam logic [11:0] OFF_DATAN  = 12'h12C;
  // Control bit positions
  localparam int B_RUN   = 0;
  localparam int B_SLEEP = 1;
  localparam int B_TYPE  = 2;
  localparam int B_MROUS = 3;
  localparam int B_PROUS = 4;
  localparam int B_LDET  = 5;
  localparam int B_OSC   = 6;
  localparam int B_ABORT = 7;
  localparam int CTRL_W  = 8;
  // Raw event bit positions
  localparam int E_MA    = 0;
  localparam int E_MB    = 1;
  localparam int E_LOW   = 2;
  localparam int E_PIN   = 3;
  localparam int EV_W    = 4;
  // Reset values and timing counts
  localparam logic [31:0] RST_MATCH = 32'hFFFFFFFF;
  localparam logic [31:0] RST_LOAD  = 32'hFFFFFFFF;
  localparam logic [15:0] RST_TRIM  = 16'h7FFF;
  localparam logic [6:0]  DIV_LAST  = 7'h7F;
  localparam logic [5:0]  TRIM_SEC  = 6'h3F;
  localparam int          DATA_WORDS = 64;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bbrpg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bbrpg_apb_rsp_t;
endpackage

// *** design/bbrpg_top.sv ***
`timescale 1ns/1ps
module bbrpg_top
  import bbrpg_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire bbrpg_pkg::bbrpg_apb_req_t i_apb,
  input  wire logic                     i_osc_input_pin,
  input  wire logic                     i_wake_n,
  input  wire logic                     i_low_cell,
  output logic                          o_regulator_off_out,
  output logic                          o_irq,
  output bbrpg_pkg::bbrpg_apb_rsp_t     o_apb
);
  typedef enum logic {BBRPG_RUN, BBRPG_OFF} bbrpg_state_t;

  bbrpg_state_t         state_q;
  logic [2:0]           sync1_q;
  logic [2:0]           sync2_q;
  logic                 osc_prev_q;
  logic [6:0]           div_q;
  logic [15:0]          pre_q;
  logic [5:0]           sec_idx_q;
  logic [31:0]          cnt_q;
  logic                 cnt_chg_q;
  logic [31:0]          match_a_q;
  logic [31:0]          match_b_q;
  logic [31:0]          load_q;
  logic [15:0]          trim_q;
  logic [CTRL_W-1:0]    ctrl_q;
  logic [EV_W-1:0]      mask_q;
  logic [EV_W-1:0]      raw_q;
  logic [31:0]          mem_q [DATA_WORDS];
  bbrpg_apb_rsp_t       rsp_q;
  logic                 off_q;
  logic                 irq_q;
  logic                 osc_s;
  logic                 osc_rise;
  logic                 slow_tick;
  logic                 sec_pulse;
  logic                 wr_en;
  logic                 rd_en;
  logic                 in_data;
  logic [5:0]           widx;
  logic [EV_W-1:0]      ev_set;
  logic                 abort_c;
  logic                 wake_c;
  logic                 enter_c;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and slow clock path
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {i_low_cell, ~i_wake_n, i_osc_input_pin};
      sync2_q <= sync1_q;
    end
  end

  assign osc_s    = sync2_q[0] & ctrl_q[B_OSC];
  assign osc_rise = osc_s & ~osc_prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      osc_prev_q <= 1'b0;
      div_q      <= 7'h00;
    end
    else
    begin
      osc_prev_q <= osc_s;
      if (osc_rise)
        div_q <= div_q + 7'h01;
    end
  end

  assign slow_tick = ctrl_q[B_TYPE] ? osc_rise : (osc_rise && div_q == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Predivider and seconds counter
  assign sec_pulse = slow_tick && ctrl_q[B_RUN] && pre_q == 16'h0000;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !ctrl_q[B_RUN])
    begin
      pre_q     <= RST_TRIM;
      sec_idx_q <= 6'h00;
    end
    else if (sec_pulse)
    begin
      sec_idx_q <= sec_idx_q + 6'h01;
      pre_q     <= (sec_idx_q == TRIM_SEC) ? trim_q : RST_TRIM;
    end
    else if (slow_tick)
      pre_q <= pre_q - 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q     <= 32'h00000000;
      cnt_chg_q <= 1'b0;
    end
    else if (wr_en && i_apb.paddr == OFF_LOAD)
    begin
      cnt_q     <= i_apb.pwdata;
      cnt_chg_q <= 1'b1;
    end
    else
    begin
      cnt_chg_q <= sec_pulse;
      if (sec_pulse)
        cnt_q <= cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_en   = i_apb.psel && i_apb.penable && rsp_q.pready && i_apb.pwrite;
  assign rd_en   = i_apb.psel && !i_apb.penable;
  assign in_data = i_apb.paddr >= OFF_DATA0 && i_apb.paddr <= OFF_DATAN
                   && i_apb.paddr[1:0] == 2'h0;
  assign widx    = 6'((i_apb.paddr - OFF_DATA0) >> 2);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      match_a_q <= RST_MATCH;
      match_b_q <= RST_MATCH;
      load_q    <= RST_LOAD;
      trim_q    <= RST_TRIM;
      mask_q    <= '0;
    end
    else if (wr_en)
    begin
      case (i_apb.paddr)
        OFF_MATCHA: match_a_q <= i_apb.pwdata;
        OFF_MATCHB: match_b_q <= i_apb.pwdata;
        OFF_LOAD:   load_q    <= i_apb.pwdata;
        OFF_TRIM:   trim_q    <= i_apb.pwdata[15:0];
        OFF_MASK:   mask_q    <= i_apb.pwdata[EV_W-1:0];
        default:    ;
      endcase
    end
  end

  // Retained words, no reset so contents survive
  always_ff @(posedge i_clk)
  begin
    if (wr_en && in_data)
      mem_q[widx] <= i_apb.pwdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and power state
  assign abort_c = ctrl_q[B_ABORT] && ctrl_q[B_LDET] && sync2_q[2];
  assign wake_c  = (ctrl_q[B_PROUS] && sync2_q[1])
                   || (ctrl_q[B_MROUS] && (ev_set[E_MA] || ev_set[E_MB]));
  assign enter_c = state_q == BBRPG_RUN && ctrl_q[B_SLEEP]
                   && (ctrl_q[B_PROUS] || ctrl_q[B_MROUS]) && !abort_c;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ctrl_q <= '0;
    else if (wr_en && i_apb.paddr == OFF_CTRL)
      ctrl_q <= i_apb.pwdata[CTRL_W-1:0];
    else if ((state_q == BBRPG_RUN && abort_c) || (state_q == BBRPG_OFF && wake_c))
      ctrl_q[B_SLEEP] <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= BBRPG_RUN;
      off_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        BBRPG_RUN:
        begin
          if (enter_c)
          begin
            state_q <= BBRPG_OFF;
            off_q   <= 1'b1;
          end
        end
        BBRPG_OFF:
        begin
          if (wake_c)
          begin
            state_q <= BBRPG_RUN;
            off_q   <= 1'b0;
          end
        end
        default:
        begin
          state_q <= BBRPG_RUN;
          off_q   <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, status and interrupt
  always_comb
  begin
    ev_set        = '0;
    ev_set[E_MA]  = cnt_chg_q && cnt_q == match_a_q;
    ev_set[E_MB]  = cnt_chg_q && cnt_q == match_b_q;
    ev_set[E_LOW] = ctrl_q[B_LDET] && sync2_q[2];
    ev_set[E_PIN] = sync2_q[1];
  end

  // Set wins over a same-cycle clear; reset or a write to CLR clears
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      raw_q <= '0;
    else if (wr_en && i_apb.paddr == OFF_CLR)
      raw_q <= (raw_q & ~i_apb.pwdata[EV_W-1:0]) | ev_set;
    else
      raw_q <= raw_q | ev_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(raw_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer, ready in the first access cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.pready <= rd_en;
      if (rd_en)
      begin
        rsp_q.pslverr <= 1'b0;
        rsp_q.prdata  <= 32'h00000000;
        case (i_apb.paddr)
          OFF_COUNT:  rsp_q.prdata <= cnt_q;
          OFF_MATCHA: rsp_q.prdata <= match_a_q;
          OFF_MATCHB: rsp_q.prdata <= match_b_q;
          OFF_LOAD:   rsp_q.prdata <= load_q;
          OFF_CTRL:   rsp_q.prdata[CTRL_W-1:0] <= ctrl_q;
          OFF_MASK:   rsp_q.prdata[EV_W-1:0] <= mask_q;
          OFF_RAW:    rsp_q.prdata[EV_W-1:0] <= raw_q;
          OFF_MIS:    rsp_q.prdata[EV_W-1:0] <= raw_q & mask_q;
          OFF_CLR:    ;
          OFF_TRIM:   rsp_q.prdata[15:0] <= trim_q;
          default:
          begin
            if (in_data)
              rsp_q.prdata <= mem_q[widx];
            else
              rsp_q.pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  assign o_apb               = rsp_q;
  assign o_regulator_off_out = off_q;
  assign o_irq               = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_off_state;
    @(posedge i_clk) disable iff (i_rst) off_q == (state_q == BBRPG_OFF);
  endproperty
  a_off_state: assert property (p_off_state) else $error("off out vs state");
  property p_enter;
    @(posedge i_clk) disable iff (i_rst) enter_c |=> o_regulator_off_out;
  endproperty
  a_enter: assert property (p_enter) else $error("no power-down");
  property p_abort;
    @(posedge i_clk) disable iff (i_rst)
      (state_q == BBRPG_RUN && abort_c) |=> !o_regulator_off_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_wake;
    @(posedge i_clk) disable iff (i_rst)
      (o_regulator_off_out && ctrl_q[B_PROUS] && sync2_q[1]) |=> !o_regulator_off_out;
  endproperty
  a_wake: assert property (p_wake) else $error("pin wake missed");
  property p_low;
    @(posedge i_clk) disable iff (i_rst)
      (ctrl_q[B_LDET] && sync2_q[2]) |=> raw_q[E_LOW];
  endproperty
  a_low: assert property (p_low) else $error("low cell flag");
  property p_irq;
    @(posedge i_clk) disable iff (i_rst) ##1 o_irq == $past(|(raw_q & mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_load;
    @(posedge i_clk) disable iff (i_rst)
      (wr_en && i_apb.paddr == OFF_LOAD) |=> cnt_q == $past(i_apb.pwdata);
  endproperty
  a_load: assert property (p_load) else $error("load lost");
  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      (!ctrl_q[B_RUN] && !(wr_en && i_apb.paddr == OFF_LOAD)) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_match;
    @(posedge i_clk) disable iff (i_rst)
      (cnt_chg_q && cnt_q == match_a_q) |=> raw_q[E_MA];
  endproperty
  a_match: assert property (p_match) else $error("match a flag");
  property p_ready;
    @(posedge i_clk) disable iff (i_rst)
      (i_apb.psel && !i_apb.penable) |=> o_apb.pready ##1 !o_apb.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing");
  c_sleep: cover property (@(posedge i_clk) disable iff (i_rst)
    !o_regulator_off_out ##1 o_regulator_off_out ##[1:50] !o_regulator_off_out);
  c_sec: cover property (@(posedge i_clk) disable iff (i_rst) sec_pulse);
  c_irq: cover property (@(posedge i_clk) disable iff (i_rst) o_irq);
endmodule

// *** verif/bbrpg_far_model.sv ***
`timescale 1ns/1ps
module bbrpg_far_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_press,
  input  wire logic i_low,
  input  wire logic i_regulator_off_out,
  output logic      o_osc,
  output logic      o_wake_n,
  output logic      o_low_cell,
  output logic      o_main_power
);
  logic osc_q = 1'b0;
  ////////////////////////////////////////////////////////////////
  // Source stands still until the host enables it
  // Fastest source the two-flop sampling can follow, one tick per two clocks
  always_ff @(posedge i_clk)
  begin
    osc_q <= i_run ? ~osc_q : 1'b0;
  end
  assign o_osc        = osc_q;
  // Pin has a pull-up, so it idles high
  assign o_wake_n     = ~i_press;
  assign o_low_cell   = i_low;
  assign o_main_power = ~i_regulator_off_out;
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import bbrpg_pkg::*;
  localparam int GAP = 2;
  logic           i_clk;
  logic           i_rst;
  bbrpg_apb_req_t i_apb;
  bbrpg_apb_rsp_t o_apb;
  logic           osc;
  logic           wake_n;
  logic           low_cell;
  logic           reg_off;
  logic           irq;
  logic           main_pwr;
  logic           run;
  logic           press;
  logic           batt_low;
  logic [31:0]    rdat;
  logic           rerr;
  int             bad_count;
  int             checked;
  ////////////////////////////////////////////////////////////////
  bbrpg_top bbrpg_top_i (
    .i_clk               (i_clk),
    .i_rst               (i_rst),
    .i_apb               (i_apb),
    .i_osc_input_pin     (osc),
    .i_wake_n            (wake_n),
    .i_low_cell          (low_cell),
    .o_regulator_off_out (reg_off),
    .o_irq               (irq),
    .o_apb               (o_apb)
  );
  bbrpg_far_model bbrpg_far_model_i (
    .i_clk               (i_clk),
    .i_run               (run),
    .i_press             (press),
    .i_low               (batt_low),
    .i_regulator_off_out (reg_off),
    .o_osc               (osc),
    .o_wake_n            (wake_n),
    .o_low_cell          (low_cell),
    .o_main_power        (main_pwr)
  );
  ////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d);
    i_apb.psel    <= 1'b1;
    i_apb.penable <= 1'b0;
    i_apb.pwrite  <= w;
    i_apb.paddr   <= a;
    i_apb.pwdata  <= d;
    @(posedge i_clk);
    i_apb.penable <= 1'b1;
    @(posedge i_clk);
    // Only the watchdog ends a wait for ready
    while (o_apb.pready !== 1'b1)
      @(posedge i_clk);
    rdat = o_apb.prdata;
    rerr = o_apb.pslverr;
  endtask
  task automatic idle(input int n);
    i_apb.psel    <= 1'b0;
    i_apb.penable <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
    idle(1 + GAP);
  endtask
  task automatic rd(input logic [11:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    idle(1);
    chk_word(rdat, e);
    chk_bit(rerr, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_bit(reg_off, 1'b0);
    chk_bit(irq, 1'b0);
    rd(OFF_COUNT, 32'h0);
    rd(OFF_MATCHA, RST_MATCH);
    rd(OFF_MATCHB, RST_MATCH);
    rd(OFF_LOAD, RST_LOAD);
    rd(OFF_TRIM, {16'h0, RST_TRIM});
    rd(OFF_RAW, 32'h0);
    xfer(1'b0, 12'h028, 32'h0);
    idle(1);
    chk_bit(rerr, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_data();
    wr(OFF_DATA0, 32'hA5C30F01);
    wr(OFF_DATAN, 32'h5A3CF0FE);
    wr(OFF_COUNT, 32'h00001234);
    xfer(1'b0, OFF_DATA0, 32'h0);
    chk_word(rdat, 32'hA5C30F01);
    xfer(1'b0, OFF_DATAN, 32'h0);
    chk_word(rdat, 32'h5A3CF0FE);
    xfer(1'b0, OFF_COUNT, 32'h0);
    idle(1);
    chk_word(rdat, 32'h0);
    $display("test data done");
  endtask
  task automatic t_clock();
    wr(OFF_CTRL, 32'h00000044);
    run <= 1'b1;
    // Direct source, so no settle wait
    idle(8);
    rd(OFF_CTRL, 32'h00000044);
    rd(OFF_COUNT, 32'h0);
    $display("test clock done");
  endtask
  task automatic t_match();
    wr(OFF_MATCHA, 32'h5);
    wr(OFF_MASK, 32'h1);
    chk_bit(irq, 1'b0);
    wr(OFF_LOAD, 32'h5);
    idle(2);
    chk_bit(irq, 1'b1);
    rd(OFF_COUNT, 32'h5);
    rd(OFF_RAW, 32'h1);
    wr(OFF_MATCHB, 32'h7);
    wr(OFF_LOAD, 32'h7);
    rd(OFF_RAW, 32'h3);
    rd(OFF_MIS, 32'h1);
    wr(OFF_LOAD, 32'h9);
    wr(OFF_CLR, 32'h3);
    rd(OFF_RAW, 32'h0);
    idle(2);
    chk_bit(irq, 1'b0);
    $display("test match done");
  endtask
  task automatic t_low();
    batt_low <= 1'b1;
    wr(OFF_CTRL, 32'h00000064);
    rd(OFF_RAW, 32'h4);
    wr(OFF_MASK, 32'h4);
    idle(2);
    chk_bit(irq, 1'b1);
    wr(OFF_CTRL, 32'h000000F6);
    idle(4);
    chk_bit(reg_off, 1'b0);
    rd(OFF_CTRL, 32'h000000F4);
    batt_low <= 1'b0;
    wr(OFF_CTRL, 32'h00000044);
    wr(OFF_CLR, 32'h4);
    rd(OFF_RAW, 32'h0);
    $display("test low cell done");
  endtask
  task automatic t_pin();
    wr(OFF_CTRL, 32'h00000056);
    idle(4);
    chk_bit(reg_off, 1'b1);
    chk_bit(main_pwr, 1'b0);
    press <= 1'b1;
    idle(6);
    chk_bit(reg_off, 1'b0);
    rd(OFF_RAW, 32'h8);
    rd(OFF_CTRL, 32'h00000054);
    press <= 1'b0;
    idle(4);
    wr(OFF_CLR, 32'h8);
    rd(OFF_RAW, 32'h0);
    $display("test pin wake done");
  endtask
  task automatic t_mwake();
    wr(OFF_MATCHA, 32'h14);
    wr(OFF_CTRL, 32'h0000004E);
    chk_bit(reg_off, 1'b1);
    wr(OFF_LOAD, 32'h14);
    idle(2);
    chk_bit(reg_off, 1'b0);
    rd(OFF_RAW, 32'h1);
    $display("test match wake done");
  endtask
  // One nominal second is 32768 ticks, two clocks each, so about 65536 clocks
  task automatic t_count();
    wr(OFF_TRIM, 32'h00008000);
    rd(OFF_TRIM, 32'h00008000);
    wr(OFF_MATCHB, 32'h00000001);
    wr(OFF_LOAD, 32'h00000000);
    wr(OFF_CLR, 32'h0000000F);
    wr(OFF_CTRL, 32'h00000045);
    idle(65400);
    rd(OFF_COUNT, 32'h00000000);
    idle(200);
    rd(OFF_COUNT, 32'h00000001);
    rd(OFF_RAW, 32'h00000002);
    wr(OFF_CTRL, 32'h00000044);
    idle(8);
    rd(OFF_COUNT, 32'h00000001);
    $display("test count done");
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (80000) @(posedge i_clk);
    bad_count++;
    results();
  end
  initial
  begin
    i_rst     = 1'b1;
    i_apb     = '0;
    run       = 1'b0;
    press     = 1'b0;
    batt_low  = 1'b0;
    bad_count = 0;
    checked   = 0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_data();
    t_clock();
    t_match();
    t_low();
    t_pin();
    t_mwake();
    t_count();
    results();
  end
endmodule
